// File: hdl/buck_seq_pkg.sv
// Constants and types for the buck start-up and over-current sequencer
// What this block does
// - Switch at fixed internal 300 kHz rate
// - Apply low-side drive once switch node falls
// - Apply high-side drive once low-side gate fell
// - Watchdog turns low-side on if node stays high
// - Ramp reference 0 to 0.8 V in 4.5 ms
// - Trip during soft-start stops ramp, gates off
// - Soft-start only after supply and limit sampling
// - Mask low-side until high-side starts switching
// - Unmask low-side at soft-start end regardless
// - Protection may still turn low-side on
// - Compare switch node against limits while low-side on
// - Four consecutive first-level events trip protection
// - Second level is 1.5 times, trips at once
// - Trip latches both switches off until power-up
// - Source current about 5 ms, sample limit
// - Accept sampled limit from 50 to 550 mV
// - At 600 mV clamp, use maximum, end sampling
package buck_seq_pkg;

    // Clock and switching rate
    localparam int CLK_HZ        = 100_000_000;
    localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
    localparam int SW_HZ         = 300_000;
    localparam int SW_PERIOD_CYC = CLK_HZ / SW_HZ;
    localparam int PHASE_W       = 9;

    // Start-up timing
    localparam int SS_TIME_US    = 4500;
    localparam int SS_CYC_DEF    = SS_TIME_US * CLK_MHZ;
    localparam int OCSET_TIME_US = 5000;
    localparam int OCSET_CYC_DEF = OCSET_TIME_US * CLK_MHZ;
    localparam int CNT_W         = 20;

    // Dead-time watchdog
    localparam int WDOG_NS       = 200;
    localparam int WDOG_CYC      = (WDOG_NS * CLK_MHZ) / 1000;
    localparam int WDOG_W        = 6;

    // Voltages in millivolts
    localparam int MV_W                    = 10;
    localparam logic [MV_W-1:0] REF_FINAL_MV = 10'h320;
    localparam logic [MV_W-1:0] LIMIT_MIN_MV = 10'h032;
    localparam logic [MV_W-1:0] LIMIT_MAX_MV = 10'h226;
    localparam logic [MV_W-1:0] CLAMP_MV     = 10'h258;

    // Over-current counting
    localparam logic [2:0] OC_CONSEC = 3'h4;

    // Sequence states
    typedef enum logic [2:0] {
        SEQ_WAIT_SUPPLY = 3'b000,
        SEQ_SAMPLE      = 3'b001,
        SEQ_SOFTSTART   = 3'b010,
        SEQ_RUN         = 3'b011,
        SEQ_TRIP        = 3'b100
    } seq_t;

    // Gate driver states
    typedef enum logic [2:0] {
        DRV_OFF     = 3'b000,
        DRV_HS      = 3'b001,
        DRV_DEAD_HS = 3'b010,
        DRV_LS      = 3'b011,
        DRV_DEAD_LS = 3'b100
    } drv_t;

endpackage

// File: hdl/sw_timing_if.sv
// Switching-cycle timing carrier between oscillator and sequencer
`timescale 1ns/100ps
`default_nettype none
interface sw_timing_if;
    import buck_seq_pkg::*;
    logic               tick;
    logic [PHASE_W-1:0] phase_cnt;
    modport src (output tick, output phase_cnt);
    modport dst (input tick, input phase_cnt);
endinterface
`default_nettype wire

// File: hdl/sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module sync3
    #(parameter int WIDTH = 1)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sync_st_t;

    sync_st_t st_q;
    sync_st_t st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Take a change once the later two stages agree
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_q.s2[i] == st_q.s3[i])
            begin
                st_d.q[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.q;
endmodule // sync3
`default_nettype wire

// File: hdl/sw_osc.sv
// Fixed-rate switching oscillator
`timescale 1ns/100ps
`default_nettype none
module sw_osc
    import buck_seq_pkg::*;
(
    // Clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    // Timing out
    sw_timing_if.src    tim
);
    typedef struct packed {
        logic [PHASE_W-1:0] cnt;
        logic               tick;
    } osc_st_t;

    osc_st_t st_q;
    osc_st_t st_d;

    always_comb
    begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == PHASE_W'(SW_PERIOD_CYC - 1))
        begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
        end
        else
        begin
            st_d.cnt = st_q.cnt + PHASE_W'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign tim.tick      = st_q.tick;
    assign tim.phase_cnt = st_q.cnt;
endmodule // sw_osc
`default_nettype wire

// File: hdl/buck_seq.sv
// Start-up, dead-time and over-current sequencer for a synchronous buck
`timescale 1ns/100ps
`default_nettype none
module buck_seq
    import buck_seq_pkg::*;
#(
    parameter int SS_CYCLES    = SS_CYC_DEF,
    parameter int OCSET_CYCLES = OCSET_CYC_DEF
)
(
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // Analog comparator and status inputs
    input  wire logic            supply_ok_i,
    input  wire logic            pwm_cmp_i,
    input  wire logic            phase_low_i,
    input  wire logic            lgate_low_i,
    input  wire logic            protect_ls_req_i,
    // Sampled voltages
    input  wire logic [MV_W-1:0] limit_pin_mv_i,
    input  wire logic [MV_W-1:0] phase_drop_mv_i,
    // Gate drive
    output logic                 high_side_switch_o,
    output logic                 low_side_switch_o,
    output logic                 limit_sample_current_o,
    // Status
    output logic [MV_W-1:0]      ref_mv_o,
    output logic [MV_W-1:0]      limit_mv_o,
    output logic                 low_side_startup_mask_o,
    output logic                 overcurrent_trip_o,
    output logic                 softstart_done_o
);
    typedef struct packed {
        seq_t              seq;
        drv_t              drv;
        logic [WDOG_W-1:0] wdog;
        logic [CNT_W-1:0]  sample_cnt;
        logic [CNT_W-1:0]  ss_acc;
        logic [MV_W-1:0]   ref_mv;
        logic [MV_W-1:0]   limit;
        logic              oc_seen;
        logic [2:0]        oc_cnt;
        logic              hs_started;
        logic              mask;
        logic              trip;
        logic              hs;
        logic              ls;
        logic              ls_out;
        logic              hs_out;
        logic              isrc;
        logic              done;
    } seq_st_t;

    seq_st_t st_q;
    seq_st_t st_d;

    // Synchronised inputs
    logic [4:0]        flags_s;
    logic [2*MV_W-1:0] mv_s;
    logic              supply_ok_s;
    logic              pwm_cmp_s;
    logic              phase_low_s;
    logic              lgate_low_s;
    logic              protect_s;
    logic [MV_W-1:0]   limit_pin_s;
    logic [MV_W-1:0]   phase_drop_s;

    // Derived limits
    logic [MV_W:0]     limit2;
    logic              oc_lvl1;
    logic              oc_lvl2;
    logic              running;

    sw_timing_if tim ();

    sw_osc u_osc
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tim   (tim)
    );

    sync3 #(.WIDTH(5)) u_sync_flags
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({supply_ok_i, pwm_cmp_i, phase_low_i, lgate_low_i, protect_ls_req_i}),
        .q_o   (flags_s)
    );

    sync3 #(.WIDTH(2*MV_W)) u_sync_mv
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({limit_pin_mv_i, phase_drop_mv_i}),
        .q_o   (mv_s)
    );

    assign supply_ok_s  = flags_s[4];
    assign pwm_cmp_s    = flags_s[3];
    assign phase_low_s  = flags_s[2];
    assign lgate_low_s  = flags_s[1];
    assign protect_s    = flags_s[0];
    assign limit_pin_s  = mv_s[2*MV_W-1:MV_W];
    assign phase_drop_s = mv_s[MV_W-1:0];

    // Second level at 1.5 times the first
    assign limit2  = {1'b0, st_q.limit} + {2'b00, st_q.limit[MV_W-1:1]};
    assign running = (st_q.seq == SEQ_SOFTSTART) || (st_q.seq == SEQ_RUN);
    assign oc_lvl1 = st_q.ls && (phase_drop_s > st_q.limit);
    assign oc_lvl2 = st_q.ls && ({1'b0, phase_drop_s} > limit2);

    always_comb
    begin
        st_d = st_q;

        // Start-up sequence
        case (st_q.seq)
            SEQ_WAIT_SUPPLY:
            begin
                st_d.hs = 1'b0;
                st_d.ls = 1'b0;
                if (supply_ok_s)
                begin
                    st_d.seq        = SEQ_SAMPLE;
                    st_d.sample_cnt = '0;
                    st_d.isrc       = 1'b1;
                end
            end
            SEQ_SAMPLE:
            begin
                st_d.hs         = 1'b0;
                st_d.ls         = 1'b0;
                st_d.sample_cnt = st_q.sample_cnt + CNT_W'(1);
                if (limit_pin_s >= CLAMP_MV)
                begin
                    st_d.limit = LIMIT_MAX_MV;
                    st_d.isrc  = 1'b0;
                end
                else if (st_q.sample_cnt == CNT_W'(OCSET_CYCLES - 1))
                begin
                    st_d.isrc = 1'b0;
                    if (limit_pin_s < LIMIT_MIN_MV)
                    begin
                        st_d.limit = LIMIT_MIN_MV;
                    end
                    else if (limit_pin_s > LIMIT_MAX_MV)
                    begin
                        st_d.limit = LIMIT_MAX_MV;
                    end
                    else
                    begin
                        st_d.limit = limit_pin_s;
                    end
                end
                if (!st_d.isrc)
                begin
                    st_d.seq        = SEQ_SOFTSTART;
                    st_d.ss_acc     = '0;
                    st_d.ref_mv     = '0;
                    st_d.mask       = 1'b1;
                    st_d.hs_started = 1'b0;
                    st_d.drv        = DRV_OFF;
                    st_d.oc_cnt     = '0;
                    st_d.oc_seen    = 1'b0;
                end
            end
            SEQ_SOFTSTART:
            begin
                // Linear ramp by error accumulation
                if (st_q.ss_acc + CNT_W'(REF_FINAL_MV) >= CNT_W'(SS_CYCLES))
                begin
                    st_d.ss_acc = st_q.ss_acc + CNT_W'(REF_FINAL_MV) - CNT_W'(SS_CYCLES);
                    st_d.ref_mv = st_q.ref_mv + MV_W'(1);
                end
                else
                begin
                    st_d.ss_acc = st_q.ss_acc + CNT_W'(REF_FINAL_MV);
                end
                if (st_q.ref_mv == REF_FINAL_MV)
                begin
                    st_d.ref_mv = REF_FINAL_MV;
                    st_d.seq    = SEQ_RUN;
                    st_d.done   = 1'b1;
                    st_d.mask   = 1'b0;
                end
            end
            SEQ_RUN:
            begin
                st_d.ref_mv = REF_FINAL_MV;
            end
            SEQ_TRIP:
            begin
                st_d.hs = 1'b0;
                st_d.ls = 1'b0;
            end
            default:
            begin
                st_d.seq = SEQ_WAIT_SUPPLY;
            end
        endcase

        // Gate driver with adaptive dead time
        if (running)
        begin
            case (st_q.drv)
                DRV_OFF:
                begin
                    if (tim.tick)
                    begin
                        st_d.drv = DRV_DEAD_LS;
                    end
                end
                DRV_DEAD_LS:
                begin
                    st_d.ls = 1'b0;
                    if (lgate_low_s && !st_q.ls)
                    begin
                        if (pwm_cmp_s)
                        begin
                            st_d.hs  = 1'b1;
                            st_d.drv = DRV_HS;
                        end
                        else
                        begin
                            st_d.wdog = '0;
                            st_d.drv  = DRV_DEAD_HS;
                        end
                    end
                end
                DRV_HS:
                begin
                    st_d.hs_started = 1'b1;
                    if (!st_q.mask || st_q.hs_started)
                    begin
                        st_d.mask = 1'b0;
                    end
                    if (!pwm_cmp_s || tim.tick)
                    begin
                        st_d.hs   = 1'b0;
                        st_d.wdog = '0;
                        st_d.drv  = DRV_DEAD_HS;
                    end
                end
                DRV_DEAD_HS:
                begin
                    st_d.wdog = st_q.wdog + WDOG_W'(1);
                    if (tim.tick)
                    begin
                        st_d.drv = DRV_DEAD_LS;
                    end
                    else if (phase_low_s || st_q.wdog == WDOG_W'(WDOG_CYC - 1))
                    begin
                        if (st_q.mask)
                        begin
                            st_d.drv = DRV_OFF;
                        end
                        else
                        begin
                            st_d.ls  = 1'b1;
                            st_d.drv = DRV_LS;
                        end
                    end
                end
                DRV_LS:
                begin
                    if (tim.tick)
                    begin
                        st_d.ls  = 1'b0;
                        st_d.drv = DRV_DEAD_LS;
                    end
                end
                default:
                begin
                    st_d.drv = DRV_OFF;
                end
            endcase

            // Over-current detection and counting
            if (oc_lvl1)
            begin
                st_d.oc_seen = 1'b1;
            end
            if (tim.tick)
            begin
                st_d.oc_seen = 1'b0;
                if (st_q.oc_seen || oc_lvl1)
                begin
                    st_d.oc_cnt = st_q.oc_cnt + 3'h1;
                    if (st_q.oc_cnt == OC_CONSEC - 3'h1)
                    begin
                        st_d.trip = 1'b1;
                    end
                end
                else
                begin
                    st_d.oc_cnt = '0;
                end
            end
            if (oc_lvl2)
            begin
                st_d.trip = 1'b1;
            end
        end

        // Latched trip overrides everything
        if (st_d.trip)
        begin
            st_d.seq  = SEQ_TRIP;
            st_d.drv  = DRV_OFF;
            st_d.hs   = 1'b0;
            st_d.ls   = 1'b0;
            st_d.done = 1'b0;
        end

        // Output stage, protection bypasses the start-up mask
        if (st_d.trip)
        begin
            st_d.hs_out = 1'b0;
            st_d.ls_out = 1'b0;
        end
        else if (protect_s && st_d.seq != SEQ_SAMPLE)
        begin
            // Release goes back through the low-side gate check
            st_d.hs     = 1'b0;
            st_d.ls     = 1'b0;
            st_d.drv    = DRV_DEAD_LS;
            st_d.hs_out = 1'b0;
            st_d.ls_out = 1'b1;
        end
        else
        begin
            st_d.hs_out = st_d.hs;
            st_d.ls_out = st_d.ls;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign high_side_switch_o      = st_q.hs_out;
    assign low_side_switch_o       = st_q.ls_out;
    assign limit_sample_current_o  = st_q.isrc;
    assign ref_mv_o                = st_q.ref_mv;
    assign limit_mv_o              = st_q.limit;
    assign low_side_startup_mask_o = st_q.mask;
    assign overcurrent_trip_o      = st_q.trip;
    assign softstart_done_o        = st_q.done;
endmodule // buck_seq
`default_nettype wire

// File: bench/buck_seq_monitor.sv
// Port checker for the buck sequencer
`timescale 1ns/100ps
`default_nettype none
module buck_seq_monitor
    import buck_seq_pkg::*;
#(
    parameter int OCSET_CYCLES = OCSET_CYC_DEF
)
(
    // Clock and reset
    input wire logic            clk_i,
    input wire logic            rst_i,
    // Inputs
    input wire logic            supply_ok_i,
    input wire logic            pwm_cmp_i,
    input wire logic            phase_low_i,
    input wire logic            lgate_low_i,
    input wire logic            protect_ls_req_i,
    input wire logic [MV_W-1:0] limit_pin_mv_i,
    input wire logic [MV_W-1:0] phase_drop_mv_i,
    // Outputs
    input wire logic            high_side_switch_o,
    input wire logic            low_side_switch_o,
    input wire logic            limit_sample_current_o,
    input wire logic [MV_W-1:0] ref_mv_o,
    input wire logic [MV_W-1:0] limit_mv_o,
    input wire logic            low_side_startup_mask_o,
    input wire logic            overcurrent_trip_o,
    input wire logic            softstart_done_o
);
    logic [CNT_W-1:0] src_cnt_q;
    logic [3:0]       quiet_q;

    // Sample length and cycles since a protection request
    always_ff @(posedge clk_i)
    begin
        src_cnt_q <= (rst_i || !limit_sample_current_o) ? '0 : src_cnt_q + 1'b1;
        quiet_q   <= (rst_i || protect_ls_req_i) ? 4'h0 : (quiet_q == 4'hf ? quiet_q : quiet_q + 4'h1);
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    no_overlap_a: assert property (!(high_side_switch_o && low_side_switch_o)) else $error("both on");
    hs_after_lgate_a: assert property ($rose(high_side_switch_o) |-> $past(lgate_low_i, 3))
        else $error("high side before gate fell");
    ls_follows_hs_a: assert property ($fell(high_side_switch_o) && !low_side_startup_mask_o
        && !overcurrent_trip_o |-> ##[1:24] (low_side_switch_o || overcurrent_trip_o)) else $error("low side late");
    mask_blocks_a: assert property (low_side_startup_mask_o && quiet_q == 4'hf |-> !low_side_switch_o)
        else $error("masked low side on");
    prot_drives_a: assert property ((protect_ls_req_i && !limit_sample_current_o
        && !overcurrent_trip_o) [*8] |-> ##[0:8] (low_side_switch_o || overcurrent_trip_o))
        else $error("request ignored");
    trip_gates_a: assert property (overcurrent_trip_o |-> !high_side_switch_o
        && !low_side_switch_o && !softstart_done_o) else $error("gates on in trip");
    trip_latched_a: assert property (overcurrent_trip_o |=> overcurrent_trip_o
        && $stable(ref_mv_o)) else $error("trip released");
    sample_bound_a: assert property (src_cnt_q <= OCSET_CYCLES + 1) else $error("sampling too long");
    sample_quiet_a: assert property (limit_sample_current_o |-> !high_side_switch_o
        && !low_side_switch_o && ref_mv_o == 10'h000) else $error("activity in sampling");
    ramp_up_a: assert property (ref_mv_o != $past(ref_mv_o) |-> ref_mv_o > $past(ref_mv_o)
        && ref_mv_o <= REF_FINAL_MV) else $error("ramp not rising");
    done_final_a: assert property ($rose(softstart_done_o) |-> ref_mv_o == REF_FINAL_MV
        ##[0:1] !low_side_startup_mask_o) else $error("done early");
    limit_range_a: assert property (ref_mv_o != 10'h000 |-> limit_mv_o >= LIMIT_MIN_MV
        && limit_mv_o <= LIMIT_MAX_MV) else $error("limit out of range");
endmodule // buck_seq_monitor

bind buck_seq buck_seq_monitor #(.OCSET_CYCLES(OCSET_CYCLES)) i_mon (.*);
`default_nettype wire

// File: bench/power_stage_model.sv
// Switch pair and switch node model
`timescale 1ns/100ps
`default_nettype none
module power_stage_model
(
    // Clock
    input  wire logic       clk_i,
    // Gate drive
    input  wire logic       high_side_switch_i,
    input  wire logic       low_side_switch_i,
    // Test controls
    input  wire logic       node_stuck_i,
    input  wire logic [9:0] drop_level_i,
    // Sensed nodes
    output logic            phase_low_o,
    output logic            lgate_low_o,
    output logic [9:0]      phase_drop_mv_o
);
    logic [1:0] hs_off_q = 2'h0;
    logic [1:0] ls_off_q = 2'h0;
    logic [9:0] noise_q  = 10'h000;

    always_ff @(posedge clk_i)
    begin
        hs_off_q <= {hs_off_q[0], !high_side_switch_i};
        ls_off_q <= {ls_off_q[0], !low_side_switch_i};
        noise_q  <= noise_q + 10'h0b5;
    end
    // Node falls two cycles after the high side opens
    assign phase_low_o     = &hs_off_q && !node_stuck_i;
    assign lgate_low_o     = &ls_off_q;
    // Drop reads only while the low side conducts
    assign phase_drop_mv_o = low_side_switch_i ? drop_level_i : (noise_q & 10'h01f);
endmodule // power_stage_model
`default_nettype wire

// File: bench/buck_seq_bench.sv
// Self-checking bench for the buck sequencer
`timescale 1ns/100ps
`default_nettype none
module buck_seq_bench;
    import buck_seq_pkg::*;
    localparam int SS_N = 1600;
    localparam int OC_N = 200;
    logic            clk_i = 1'b0, rst_i = 1'b1, supply_ok_i = 1'b0, pwm_cmp_i = 1'b0;
    logic            protect_ls_req_i = 1'b0, node_stuck = 1'b0;
    logic [MV_W-1:0] limit_pin_mv_i = 10'h000, drop_level = 10'h000;
    logic            phase_low_i, lgate_low_i, high_side_switch_o, low_side_switch_o;
    logic            limit_sample_current_o, low_side_startup_mask_o, overcurrent_trip_o, softstart_done_o;
    logic [MV_W-1:0] phase_drop_mv_i, ref_mv_o, limit_mv_o;
    int              miscompares = 0, checks_done = 0, on_time = 60, on_cnt = 0, k;
    int              pins[3] = '{20, 560, 700};
    bit              prebias = 1'b0;
    logic [31:0]     seed = 32'h70cb;

    buck_seq #(.SS_CYCLES(SS_N), .OCSET_CYCLES(OC_N)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok_i), .pwm_cmp_i(pwm_cmp_i),
        .phase_low_i(phase_low_i), .lgate_low_i(lgate_low_i), .protect_ls_req_i(protect_ls_req_i),
        .limit_pin_mv_i(limit_pin_mv_i), .phase_drop_mv_i(phase_drop_mv_i),
        .high_side_switch_o(high_side_switch_o), .low_side_switch_o(low_side_switch_o),
        .limit_sample_current_o(limit_sample_current_o), .ref_mv_o(ref_mv_o), .limit_mv_o(limit_mv_o),
        .low_side_startup_mask_o(low_side_startup_mask_o), .overcurrent_trip_o(overcurrent_trip_o),
        .softstart_done_o(softstart_done_o));

    power_stage_model i_stage (
        .clk_i(clk_i), .high_side_switch_i(high_side_switch_o), .low_side_switch_i(low_side_switch_o),
        .node_stuck_i(node_stuck), .drop_level_i(drop_level), .phase_low_o(phase_low_i),
        .lgate_low_o(lgate_low_i), .phase_drop_mv_o(phase_drop_mv_i));

    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // Comparator ends each pulse after on_time cycles
    always_ff @(posedge clk_i)
    begin
        on_cnt    <= high_side_switch_o ? on_cnt + 1 : 0;
        pwm_cmp_i <= !prebias && (on_cnt < on_time);
    end

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int exp_limit(input int pin);
        if (pin < 50)
            return 50;
        if (pin > 550)
            return 550;
        return pin;
    endfunction

    task automatic step();
        @(posedge clk_i);
        #1;
    endtask

    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wait_sig(ref logic s, input logic v, input int lim, output int n);
        for (n = 0; n < lim && s !== v; n++)
            step();
    endtask

    task automatic run_case(input int pin, input int mode);
        int n, t, t2, lim, consec, bad;
        bit pat[$];
        pat = '{1, 1, 1, 0, 1, 1, 1, 1};
        lim = exp_limit(pin);
        prebias = (mode == 1);
        node_stuck <= (mode == 3);
        rst_i <= 1'b1;
        supply_ok_i <= 1'b0;
        drop_level <= 10'h000;
        limit_pin_mv_i <= pin[9:0];
        repeat (4) step();
        rst_i <= 1'b0;
        repeat (3) step();
        supply_ok_i <= 1'b1;
        wait_sig(limit_sample_current_o, 1'b1, 20, n);
        wait_sig(limit_sample_current_o, 1'b0, OC_N + 10, n);
        compare("sample span", 1, n > 0 && (pin >= 600 ? n < 8 : n inside {[OC_N-1:OC_N+1]}));
        limit_pin_mv_i <= 10'h3ff ^ pin[9:0];
        bad = 0;
        t2 = 0;
        for (t = 0; t < SS_N + 400 && softstart_done_o !== 1'b1 && overcurrent_trip_o !== 1'b1; t++)
        begin
            step();
            protect_ls_req_i <= (mode == 1 && t >= 300 && t < 320);
            if (mode == 1 && t == 319)
                compare("forced low side", 1, low_side_switch_o);
            else if (mode == 1 && (t < 300 || t > 340) && low_side_switch_o === 1'b1)
                bad++;
            if (mode == 2 && t2 == 0 && t > 5 && low_side_startup_mask_o === 1'b0)
            begin
                drop_level <= 10'(lim + lim / 2 + 1);
                t2 = t;
            end
        end
        compare("limit held", lim, limit_mv_o);
        if (mode == 2)
        begin
            compare("trip in ramp", 1, overcurrent_trip_o);
            compare("second level quick", 1, t2 > 0 && t - t2 < 360);
            compare("ramp held", 1, ref_mv_o < REF_FINAL_MV);
            return;
        end
        compare("ramp time", 1, t >= SS_N - 2 && t <= SS_N + 12);
        compare("final ref", REF_FINAL_MV, ref_mv_o);
        if (mode == 1)
        begin
            compare("masked low side", 0, bad);
            wait_sig(low_side_switch_o, 1'b1, 700, n);
            compare("low side after ramp", 1, low_side_switch_o);
            return;
        end
        wait_sig(high_side_switch_o, 1'b0, 400, n);
        wait_sig(high_side_switch_o, 1'b1, 400, n);
        wait_sig(high_side_switch_o, 1'b0, 400, t);
        wait_sig(low_side_switch_o, 1'b1, 400, t2);
        if (mode == 3)
            compare("watchdog delay", WDOG_CYC, t2);
        else
            compare("node fall fast", 1, t2 < WDOG_CYC);
        wait_sig(high_side_switch_o, 1'b1, 400, n);
        compare("switching period", SW_PERIOD_CYC, t + t2 + n);
        consec = 0;
        foreach (pat[i])
        begin
            wait_sig(low_side_switch_o, 1'b0, 400, n);
            wait_sig(low_side_switch_o, 1'b1, 400, n);
            compare("early trip", consec >= 4, overcurrent_trip_o);
            drop_level <= pat[i] ? 10'(lim + 1) : 10'(lim);
            consec = pat[i] ? consec + 1 : 0;
        end
        wait_sig(overcurrent_trip_o, 1'b1, 400, n);
        compare("trip after four", 1, overcurrent_trip_o);
        protect_ls_req_i <= 1'b1;
        repeat (50) step();
        compare("gates in trip", 3'b100, {overcurrent_trip_o, high_side_switch_o, low_side_switch_o});
        protect_ls_req_i <= 1'b0;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #600000;
        miscompares++;
        complete_run();
    end

    initial
    begin
        for (k = 0; k < 4; k++)
        begin
            on_time = 20 + int'(next_rand() % 100);
            run_case(k == 3 ? 50 + int'(next_rand() % 501) : pins[k], k);
            $display("test %0d ended, mismatches %0d", k, miscompares);
        end
        complete_run();
    end
endmodule // buck_seq_bench
`default_nettype wire
